// *** hdl/slot_decoder_regs.svh ***
`ifndef SLOT_DECODER_REGS_SVH
`define SLOT_DECODER_REGS_SVH
// Byte positions inside an allocation block
`define BLK_ATTR_BYTE      2'h0
`define BLK_START_LO_BYTE  2'h1
`define BLK_START_HI_BYTE  2'h2
`define BLK_ADDR_BYTE      2'h3
// Attribute bitmap fields
`define ATTR_EP_MSB        3
`define ATTR_EP_LSB        0
`define ATTR_DIR_BIT       4
`define ATTR_SETUP_BIT     5
`define ATTR_TYPE_MSB      7
`define ATTR_TYPE_LSB      6
// Setup data length in bytes
`define SETUP_BYTES        4'h8
// Register offsets (byte addresses)
`define REG_CTRL           5'h00
`define REG_STATUS         5'h04
`define REG_SLOT           5'h08
`define REG_SETUP_LO       5'h0C
`define REG_SETUP_HI       5'h10
`define CTRL_RESET         32'h00000000
`define AXI_OKAY           2'h0
`define AXI_SLVERR         2'h2
`endif

// *** hdl/slot_decoder_pkg.sv ***
package slot_decoder_pkg;
   // Block type codes
   typedef enum logic [1:0]
   {
      BLOCK_RECEIVE  = 2'h0,
      BLOCK_TRANSMIT = 2'h1,
      BLOCK_NOTIFY   = 2'h2,
      BLOCK_RESERVED = 2'h3
   } block_kind_type;
   // Slot action presented to the endpoint logic
   typedef enum logic [1:0]
   {
      ACT_NONE      = 2'h0,
      ACT_LISTEN    = 2'h1,
      ACT_HANDSHAKE = 2'h2,
      ACT_DATA_HS   = 2'h3
   } action_type;
   // Parser states
   typedef enum logic [1:0]
   {
      PS_HEADER = 2'h0,
      PS_SETUP  = 2'h1
   } parse_type;
endpackage : slot_decoder_pkg

// *** hdl/slot_allocation_block_decoder.sv ***
`timescale 1ns/1ps
`include "slot_decoder_regs.svh"
`default_nettype none
module slot_allocation_block_decoder
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Control packet byte stream
   input  wire logic        blockStart,
   input  wire logic        byteValid,
   input  wire logic [7:0]  byteData,
   // Slot decision
   output var  logic        slotValid,
   output var  logic [1:0]  slotAction,
   output var  logic        slotDirIn,
   output var  logic [3:0]  slotEndpoint,
   output var  logic [15:0] slotStartUs,
   output var  logic        slotSetup,
   output var  logic        setupValid,
   output var  logic [63:0] setupData,
   // AXI4-Lite slave
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   ////////////////////////////////////////////////////////////////////////
   // Parser state
   slot_decoder_pkg::parse_type pState, next_pState;
   logic [1:0]  byteIdx, next_byteIdx;
   logic [3:0]  setupCnt, next_setupCnt;
   logic [7:0]  attr, next_attr;
   logic [15:0] startOfs, next_startOfs;
   logic [31:0] ctrl, next_ctrl;
   logic [7:0]  blockCount, next_blockCount;
   logic        next_slotValid, next_slotDirIn, next_slotSetup;
   logic        next_setupValid;
   logic [1:0]  next_slotAction;
   logic [3:0]  next_slotEndpoint;
   logic [15:0] next_slotStartUs;
   logic [63:0] next_setupData;
   logic        byteDataOwner, next_byteDataOwner;

   // Own address and decoder enable come from the control register
   logic [7:0] ownAddr;
   logic       decodeEn;
   assign ownAddr  = ctrl[7:0];
   assign decodeEn = ctrl[8];

   // Map the attribute bitmap to an action; receive ignores bit 4
   function automatic slot_decoder_pkg::action_type actionOf
      (input logic [7:0] a);
      slot_decoder_pkg::block_kind_type k;
      k = slot_decoder_pkg::block_kind_type'(
             a[`ATTR_TYPE_MSB:`ATTR_TYPE_LSB]);
      case (k)
         slot_decoder_pkg::BLOCK_RECEIVE:
            actionOf = slot_decoder_pkg::ACT_LISTEN;
         slot_decoder_pkg::BLOCK_TRANSMIT:
            actionOf = a[`ATTR_DIR_BIT] ?
                       slot_decoder_pkg::ACT_DATA_HS :
                       slot_decoder_pkg::ACT_HANDSHAKE;
         default:
            actionOf = slot_decoder_pkg::ACT_NONE;
      endcase
   endfunction : actionOf

   ////////////////////////////////////////////////////////////////////////
   // Block parsing: one byte per valid cycle, restarted by blockStart
   always_comb
   begin
      next_pState       = pState;
      next_byteIdx      = byteIdx;
      next_setupCnt     = setupCnt;
      next_attr         = attr;
      next_startOfs     = startOfs;
      next_blockCount   = blockCount;
      next_slotValid    = 1'b0;
      next_setupValid   = 1'b0;
      next_slotAction   = slotAction;
      next_slotDirIn    = slotDirIn;
      next_slotEndpoint = slotEndpoint;
      next_slotStartUs  = slotStartUs;
      next_slotSetup    = slotSetup;
      next_setupData    = setupData;
      if (blockStart)
      begin
         next_pState  = slot_decoder_pkg::PS_HEADER;
         next_byteIdx = `BLK_ATTR_BYTE;
      end
      else if (byteValid && decodeEn)
      begin
         case (pState)
            slot_decoder_pkg::PS_HEADER:
            begin
               next_byteIdx = byteIdx + 2'h1;
               case (byteIdx)
                  `BLK_ATTR_BYTE:     next_attr = byteData;
                  `BLK_START_LO_BYTE: next_startOfs[7:0] = byteData;
                  `BLK_START_HI_BYTE: next_startOfs[15:8] = byteData;
                  default:
                  begin
                     // Address byte closes the header; others are skipped
                     if (byteData == ownAddr &&
                         actionOf(attr) != slot_decoder_pkg::ACT_NONE)
                     begin
                        next_slotValid    = 1'b1;
                        next_slotAction   = actionOf(attr);
                        next_slotDirIn    = attr[`ATTR_TYPE_LSB] &
                                            attr[`ATTR_DIR_BIT];
                        next_slotEndpoint = attr[`ATTR_EP_MSB:`ATTR_EP_LSB];
                        next_slotStartUs  = startOfs;
                        next_slotSetup    = attr[`ATTR_SETUP_BIT];
                        next_blockCount   = blockCount + 8'h01;
                     end
                     // Setup bytes follow any receive or transmit setup block, matched or not
                     if (attr[`ATTR_SETUP_BIT] &&
                         actionOf(attr) != slot_decoder_pkg::ACT_NONE)
                     begin
                        next_pState   = slot_decoder_pkg::PS_SETUP;
                        next_setupCnt = 4'h0;
                     end
                  end
               endcase
            end
            slot_decoder_pkg::PS_SETUP:
            begin
               next_setupData = {byteData, setupData[63:8]};
               next_setupCnt  = setupCnt + 4'h1;
               if (setupCnt == `SETUP_BYTES - 4'h1)
               begin
                  next_pState     = slot_decoder_pkg::PS_HEADER;
                  next_byteIdx    = `BLK_ATTR_BYTE;
                  next_setupValid = (byteDataOwner == 1'b1);
               end
            end
            default: next_pState = slot_decoder_pkg::PS_HEADER;
         endcase
      end
   end

   // Remember whether the setup bytes belong to this device
   always_comb
   begin
      next_byteDataOwner = byteDataOwner;
      if (next_slotValid)
         next_byteDataOwner = next_slotSetup;
      else if (byteValid && decodeEn && pState == slot_decoder_pkg::PS_HEADER
               && byteIdx == `BLK_ADDR_BYTE)
         next_byteDataOwner = 1'b0;
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pState        <= slot_decoder_pkg::PS_HEADER;
         byteIdx       <= 2'h0;
         setupCnt      <= 4'h0;
         attr          <= 8'h00;
         startOfs      <= 16'h0000;
         blockCount    <= 8'h00;
         slotValid     <= 1'b0;
         slotAction    <= slot_decoder_pkg::ACT_NONE;
         slotDirIn     <= 1'b0;
         slotEndpoint  <= 4'h0;
         slotStartUs   <= 16'h0000;
         slotSetup     <= 1'b0;
         setupValid    <= 1'b0;
         setupData     <= 64'h0000000000000000;
         byteDataOwner <= 1'b0;
      end
      else
      begin
         pState        <= next_pState;
         byteIdx       <= next_byteIdx;
         setupCnt      <= next_setupCnt;
         attr          <= next_attr;
         startOfs      <= next_startOfs;
         blockCount    <= next_blockCount;
         slotValid     <= next_slotValid;
         slotAction    <= next_slotAction;
         slotDirIn     <= next_slotDirIn;
         slotEndpoint  <= next_slotEndpoint;
         slotStartUs   <= next_slotStartUs;
         slotSetup     <= next_slotSetup;
         setupValid    <= next_setupValid;
         setupData     <= next_setupData;
         byteDataOwner <= next_byteDataOwner;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: write once both address and data are held
   logic        next_awready, next_wready, next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_arready, next_rvalid;
   logic [1:0]  next_rresp;
   logic [31:0] next_rdata;
   always_comb
   begin
      next_ctrl    = ctrl;
      next_awready = 1'b0;
      next_wready  = 1'b0;
      next_bvalid  = s_axi_bvalid & ~s_axi_bready;
      next_bresp   = s_axi_bresp;
      if (!s_axi_bvalid && s_axi_awvalid && s_axi_wvalid &&
          !s_axi_awready)
      begin
         next_awready = 1'b1;
         next_wready  = 1'b1;
         next_bvalid  = 1'b1;
         next_bresp   = `AXI_OKAY;
         if (s_axi_awaddr == `REG_CTRL)
         begin
            if (s_axi_wstrb[0]) next_ctrl[7:0] = s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) next_ctrl[8] = s_axi_wdata[8];
         end
         else
            next_bresp = `AXI_SLVERR;
      end
   end

   // Reads return control, parser status, last slot and setup data
   always_comb
   begin
      next_arready = 1'b0;
      next_rvalid  = s_axi_rvalid & ~s_axi_rready;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (!s_axi_rvalid && s_axi_arvalid && !s_axi_arready)
      begin
         next_arready = 1'b1;
         next_rvalid  = 1'b1;
         next_rresp   = `AXI_OKAY;
         case (s_axi_araddr)
            `REG_CTRL:     next_rdata = ctrl;
            `REG_STATUS:   next_rdata = {20'h0, pState, byteIdx, blockCount};
            `REG_SLOT:     next_rdata = {7'h0, slotSetup, slotAction,
                                         slotDirIn, 1'b0, slotEndpoint,
                                         slotStartUs};
            `REG_SETUP_LO: next_rdata = setupData[31:0];
            `REG_SETUP_HI: next_rdata = setupData[63:32];
            default:
            begin
               next_rdata = 32'h00000000;
               next_rresp = `AXI_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl          <= `CTRL_RESET;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `AXI_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `AXI_OKAY;
      end
      else
      begin
         ctrl          <= next_ctrl;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end
endmodule : slot_allocation_block_decoder
`default_nettype wire

// *** test/slot_decoder_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module slot_decoder_checker
(
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        nrst,
   // Byte stream and slot decision
   input wire logic        blockStart,
   input wire logic        byteValid,
   input wire logic [7:0]  byteData,
   input wire logic        slotValid,
   input wire logic [1:0]  slotAction,
   input wire logic        slotDirIn,
   input wire logic [3:0]  slotEndpoint,
   input wire logic [15:0] slotStartUs,
   input wire logic        setupValid
);
   logic [3:0]  idx, next_idx;
   logic [31:0] hdr, next_hdr;
   wire         take = byteValid && !blockStart;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Shadow byte index; only flagged typed blocks carry setup bytes
   always_comb
   begin
      next_idx = take ? idx + 4'h1 : idx;
      next_hdr = hdr;
      if (take && idx < 4'h4)
         next_hdr[8*idx[1:0] +: 8] = byteData;
      if (blockStart || (take && idx == 4'hB))
         next_idx = 4'h0;
      if (take && idx == 4'h3 && (hdr[7] || !hdr[5]))
         next_idx = 4'h0;
   end
   // Async clear keeps the shadow aligned after every reset
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
         {idx, hdr} <= 36'h0;
      else
         {idx, hdr} <= {next_idx, next_hdr};
   ////////////////////////////////
   recv_listen_a: assert property (slotValid && hdr[7:6] == 2'h0
      |-> slotAction == 2'h1 && !slotDirIn) else $error("bad listen");
   field_decode_a: assert property (slotValid |->
      slotEndpoint == hdr[3:0] && slotStartUs == hdr[23:8])
      else $error("bad fields");
   addr_moment_a: assert property (slotValid
      |-> $past(take && idx == 4'h3)) else $error("slot mistimed");
   tx_out_a: assert property (slotValid && hdr[7:4] == 4'h4
      |-> slotAction == 2'h2 && !slotDirIn) else $error("bad out answer");
   tx_in_a: assert property (slotValid && hdr[7:4] == 4'h5
      |-> slotAction == 2'h3 && slotDirIn) else $error("bad in answer");
   type_gate_a: assert property (slotValid |-> !hdr[7])
      else $error("wrong type accepted");
   setup_done_a: assert property (setupValid
      |-> $past(take && idx == 4'hB)) else $error("setup mistimed");
   fields_hold_a: assert property (!slotValid |->
      $stable(slotStartUs) && $stable(slotEndpoint))
      else $error("fields moved");
endmodule : slot_decoder_checker
bind slot_allocation_block_decoder slot_decoder_checker i_slot_decoder_checker
   (.core_clk, .nrst, .blockStart, .byteValid, .byteData, .slotValid,
   .slotAction, .slotDirIn, .slotEndpoint, .slotStartUs, .setupValid);
`default_nettype wire

// *** test/host_block_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_block_source
(
   // Clock and byte stream towards the device
   input  wire logic       core_clk,
   output var  logic       blockStart,
   output var  logic       byteValid,
   output var  logic [7:0] byteData
);
   // Idle stream from time zero
   initial {blockStart, byteValid, byteData} = 10'h0A5;
   // One block; bit 4 comes from the caller so a bad one can be sent
   task automatic sendBlock(input logic [31:0] hdr, input logic [63:0] setup,
                            input logic withStart, input int gap);
      logic [95:0] bytes;
      int          n;
      bytes = {setup, hdr};
      n = (hdr[5] && !hdr[7]) ? 12 : 4;
      @(posedge core_clk);
      if (withStart)
      begin
         blockStart <= 1'h1;
         @(posedge core_clk);
      end
      for (int k = 0; k < n; k++)
      begin
         {blockStart, byteValid, byteData} <= {2'h1, bytes[8*k +: 8]};
         @(posedge core_clk);
         // Idle data toggles so a stale byte is never mistaken for fresh
         if (gap > 0 || k == n - 1)
            {byteValid, byteData} <= {1'h0, ~byteData};
         repeat ((k < n - 1) ? gap : 0) @(posedge core_clk);
      end
   endtask : sendBlock
endmodule : host_block_source
`default_nettype wire

// *** test/slot_allocation_block_decoder_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module slot_allocation_block_decoder_bench;
   typedef struct packed {logic [31:0] hdr; logic [3:0] exp;} row_type;
   logic        core_clk = 1'h0, nrst = 1'h0;
   logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
   logic [31:0] s_axi_wdata = 32'h0, rd;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [1:0]  resp;
   wire         blockStart, byteValid, slotValid, slotDirIn, slotSetup;
   wire         setupValid, s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire         s_axi_arready, s_axi_rvalid;
   wire [1:0]   slotAction, s_axi_bresp, s_axi_rresp;
   wire [3:0]   slotEndpoint;
   wire [7:0]   byteData;
   wire [15:0]  slotStartUs;
   wire [31:0]  s_axi_rdata;
   wire [63:0]  setupData;
   int          bad_count = 0, check_count = 0, cycles = 0;
   // Header word beside expected valid, action and IN flag; a block that
   // does not match leaves the last action and direction in place
   row_type     rows [7] = '{{32'h2A123405, 4'hA}, {32'h2A000013, 4'hA},
      {32'h2AFFFF47, 4'hC}, {32'h2A00015F, 4'hF}, {32'h2A000083, 4'h7},
      {32'h2A0000C1, 4'h7}, {32'h2B123405, 4'h7}};
   slot_allocation_block_decoder i_slot_allocation_block_decoder
   (
      .core_clk, .nrst, .blockStart, .byteValid, .byteData, .slotValid,
      .slotAction, .slotDirIn, .slotEndpoint, .slotStartUs, .slotSetup,
      .setupValid, .setupData, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   host_block_source i_host_block_source
      (.core_clk, .blockStart, .byteValid, .byteData);
   ////////////////////////////////
   // 25 MHz clock
   always #20 core_clk = ~core_clk;
   // Hang guard; the run needs about 120 cycles
   always @(posedge core_clk)
      if (++cycles == 3000)
      begin
         bad_count++;
         end_of_test();
      end
   task automatic check(input string name, input logic [71:0] seen, exp);
      check_count++;
      if (seen !== exp)
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      bad_count += int'(seen !== exp);
   endtask : check
   task automatic end_of_test;
      if (bad_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   // One bus write or read; each valid drops once its ready is seen
   task automatic axiXfer(input logic wr, input logic [4:0] a,
                          input logic [31:0] d);
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
      {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
      do
      begin
         @(posedge core_clk);
         s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
         s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      end
      while (wr ? !s_axi_bvalid : !s_axi_rvalid);
      {resp, rd} = {wr ? s_axi_bresp : s_axi_rresp, s_axi_rdata};
      {s_axi_bready, s_axi_rready} <= 2'h0;
   endtask : axiXfer
   // Reset, decoding off, registers, table, then setup cases
   initial
   begin
      repeat (4) @(posedge core_clk);
      check("reset outs", {slotValid, slotAction, s_axi_bvalid}, 72'h0);
      nrst <= 1'h1;
      i_host_block_source.sendBlock(32'h2A123405, 64'h0, 1'h1, 0);
      #1 check("slot while off", slotValid, 72'h0);
      axiXfer(1'h1, 5'h04, 32'h12A);
      check("status write", resp, 72'h2);
      axiXfer(1'h1, 5'h00, 32'h12A);
      axiXfer(1'h0, 5'h00, 32'h0);
      check("ctrl", {resp, rd}, 72'h12A);
      axiXfer(1'h0, 5'h14, 32'h0);
      check("unmapped", {resp, rd}, 72'h200000000);
      foreach (rows[i])
      begin
         i_host_block_source.sendBlock(rows[i].hdr, 64'h0, 1'h1, i % 2);
         #1 check("decision",
            {slotValid, slotAction, slotDirIn}, rows[i].exp);
         // Endpoint from bits 3:0, start from bytes 2 and 1
         if (rows[i].exp[3])
            check("fields",
               {slotEndpoint, slotStartUs},
               {rows[i].hdr[3:0], rows[i].hdr[23:8]});
      end
      axiXfer(1'h0, 5'h08, 32'h0);
      check("slot reg", {resp, rd}, 72'hEF0001);
      // Foreign setup block, then a header with no start pulse
      i_host_block_source.sendBlock(32'h2B000021, 64'hF0E1D2C3, 1'h1, 0);
      i_host_block_source.sendBlock(32'h2A00065F, 64'h0, 1'h0, 0);
      #1 check("after setup",
         {slotValid, slotAction, slotStartUs}, 72'h70006);
      // Own setup block from a slow host
      i_host_block_source.sendBlock(32'h2A000122, 64'h0807060504030201,
                                    1'h1, 1);
      #1 check("setup",
         {setupValid, slotSetup, setupData}, 72'h30807060504030201);
      end_of_test();
   end
endmodule : slot_allocation_block_decoder_bench
`default_nettype wire
